// ### logic/pcb_cfg_header.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_cfg_header
    import pcb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration request port, one dword per request
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_done,
    output logic [31:0] cfg_rdata,
    // Downstream request from the link
    input wire logic dn_valid,
    input wire logic dn_is_mem,
    input wire logic dn_is_io,
    input wire logic dn_is_write,
    input wire logic dn_poisoned,
    output logic dn_accept,
    output logic dn_unsupported,
    output logic dn_write_invalidate,
    output logic dn_bad_parity,
    // Completions seen or sent on the link
    input wire logic cpl_poisoned_data,
    input wire logic cpl_ur_received,
    input wire logic cpl_ca_received,
    input wire logic cpl_ca_sent,
    // PCI side
    input wire logic up_valid,
    input wire logic up_is_mem,
    input wire logic up_is_io,
    output logic up_claim,
    input wire logic pci_serr_n,
    // Link side enables and messages
    output logic link_initiate_allowed,
    output logic err_msg_send
);
    pcb_ctl_if ctl ();

    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] stat_reg, stat_next;
    logic [31:0] rdata_reg, rdata_next;
    logic done_reg, done_next;
    logic serr_s1_reg, serr_s2_reg, serr_s3_reg;
    logic msg_reg, msg_next;
    logic [15:0] wr_lo, wr_hi, set_bits, clr_bits;
    logic serr_fall, wr_dw1;

    // Merge byte lanes of a 16-bit half into its old value
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0] be);
        lane_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                      be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    assign ctl.memory_space_enable = ctrl_reg[CTL_MEM];
    assign ctl.io_space_enable = ctrl_reg[CTL_IO];
    assign ctl.upstream_initiator_enable = ctrl_reg[CTL_INIT];
    assign ctl.write_invalidate_promotion_enable = ctrl_reg[CTL_MWI];
    assign ctl.parity_response_enable = ctrl_reg[CTL_PAR];

    pcb_xact_gate u_gate (
        .clock(clock),
        .rst(rst),
        .ctl(ctl),
        .dn_valid(dn_valid),
        .dn_is_mem(dn_is_mem),
        .dn_is_io(dn_is_io),
        .dn_is_write(dn_is_write),
        .dn_poisoned(dn_poisoned),
        .up_valid(up_valid),
        .up_is_mem(up_is_mem),
        .up_is_io(up_is_io),
        .dn_accept(dn_accept),
        .dn_unsupported(dn_unsupported),
        .dn_write_invalidate(dn_write_invalidate),
        .dn_bad_parity(dn_bad_parity),
        .up_claim(up_claim)
    );

    // Error pin is asynchronous to our clock
    always_ff @(posedge clock) begin
        if (rst) begin
            serr_s1_reg <= 1'b1;
            serr_s2_reg <= 1'b1;
            serr_s3_reg <= 1'b1;
        end else begin
            serr_s1_reg <= pci_serr_n;
            serr_s2_reg <= serr_s1_reg;
            serr_s3_reg <= serr_s2_reg;
        end
    end

    always_comb begin
        serr_fall = serr_s3_reg && !serr_s2_reg;
        // Error message leaves only with the report enable set
        msg_next = serr_fall && ctrl_reg[CTL_SERR];
    end

    // Control register
    always_comb begin
        wr_dw1 = cfg_valid && cfg_write && (cfg_offset[7:2] == OFS_CTRL[7:2]);
        wr_lo = lane_merge(ctrl_reg, cfg_wdata[15:0], cfg_byte_en[1:0]);
        ctrl_next = ctrl_reg;
        if (wr_dw1) begin
            // Hardwired and reserved bits never take a write
            ctrl_next = wr_lo & CTRL_WMASK;
        end
    end

    // Status register: set wins over a clear in the same cycle
    always_comb begin
        wr_hi = {cfg_byte_en[3] ? cfg_wdata[31:24] : 8'h00,
                 cfg_byte_en[2] ? cfg_wdata[23:16] : 8'h00};
        clr_bits = wr_dw1 ? (wr_hi & STAT_W1C) : 16'h0000;
        set_bits = 16'h0000;
        set_bits[ST_POISON] = ctl.poison_seen;
        set_bits[ST_MPAR] = ctl.poison_parity_event
            || (cpl_poisoned_data && ctrl_reg[CTL_PAR]);
        set_bits[ST_SERR] = msg_reg;
        set_bits[ST_UR_RCV] = cpl_ur_received;
        set_bits[ST_CA_RCV] = cpl_ca_received;
        set_bits[ST_CA_SIG] = cpl_ca_sent;
        stat_next = ((stat_reg & ~clr_bits) | set_bits) & STAT_W1C;
        stat_next[ST_CAP] = 1'b1;
    end

    // Read path and completion strobe
    always_comb begin
        rdata_next = rdata_reg;
        done_next = cfg_valid;
        if (cfg_valid) begin
            rdata_next = 32'h0000_0000;
            if (!cfg_write) begin
                unique case (cfg_offset[7:2])
                    OFS_MAKER[7:2]: rdata_next = {PART_CODE, MAKER_CODE};
                    OFS_STAT[7:2]: rdata_next = {stat_reg, ctrl_reg};
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            stat_reg <= STAT_RESET;
            rdata_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
            msg_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
            msg_reg <= msg_next;
        end
    end

    assign cfg_done = done_reg;
    assign cfg_rdata = rdata_reg;
    assign err_msg_send = msg_reg;
    assign link_initiate_allowed = ctrl_reg[CTL_INIT];
endmodule
`default_nettype wire

// ### inc/pcb_pkg.sv
package pcb_pkg;
    // Byte offsets within configuration space
    localparam logic [7:0] OFS_MAKER = 8'h00;
    localparam logic [7:0] OFS_PART = 8'h02;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h06;
    // Control field positions
    localparam int CTL_IO = 0;
    localparam int CTL_MEM = 1;
    localparam int CTL_INIT = 2;
    localparam int CTL_MWI = 4;
    localparam int CTL_PAR = 6;
    localparam int CTL_SERR = 8;
    // Status field positions
    localparam int ST_CAP = 4;
    localparam int ST_MPAR = 8;
    localparam int ST_CA_SIG = 11;
    localparam int ST_CA_RCV = 12;
    localparam int ST_UR_RCV = 13;
    localparam int ST_SERR = 14;
    localparam int ST_POISON = 15;
    // Reset values and writable masks
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h0157;
    localparam logic [15:0] STAT_RESET = 16'h0010;
    localparam logic [15:0] STAT_W1C = 16'hF900;
    // Identity codes: arbitrary neutral values
    localparam logic [15:0] MAKER_CODE = 16'h1AB5;
    localparam logic [15:0] PART_CODE = 16'h5A3C;
endpackage

// ### inc/pcb_ctl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pcb_ctl_if;
    logic memory_space_enable;
    logic io_space_enable;
    logic upstream_initiator_enable;
    logic write_invalidate_promotion_enable;
    logic parity_response_enable;
    logic poison_seen;
    logic poison_parity_event;
    modport regs (
        output memory_space_enable, io_space_enable, upstream_initiator_enable,
        output write_invalidate_promotion_enable, parity_response_enable,
        input poison_seen, poison_parity_event
    );
    modport gate (
        input memory_space_enable, io_space_enable, upstream_initiator_enable,
        input write_invalidate_promotion_enable, parity_response_enable,
        output poison_seen, poison_parity_event
    );
endinterface
`default_nettype wire

// ### logic/pcb_xact_gate.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_xact_gate
    import pcb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control enables and status events
    pcb_ctl_if.gate ctl,
    // Downstream request from the link
    input wire logic dn_valid,
    input wire logic dn_is_mem,
    input wire logic dn_is_io,
    input wire logic dn_is_write,
    input wire logic dn_poisoned,
    // Upstream cycle seen on the PCI bus
    input wire logic up_valid,
    input wire logic up_is_mem,
    input wire logic up_is_io,
    // Decisions, one cycle after the request
    output logic dn_accept,
    output logic dn_unsupported,
    output logic dn_write_invalidate,
    output logic dn_bad_parity,
    output logic up_claim
);
    logic acc_reg, acc_next, ur_reg, ur_next, mwi_reg, mwi_next;
    logic bp_reg, bp_next, claim_reg, claim_next;
    logic dn_ok;

    always_comb begin
        dn_ok = (dn_is_mem && ctl.memory_space_enable)
            || (dn_is_io && ctl.io_space_enable);
        acc_next = dn_valid && dn_ok;
        ur_next = dn_valid && !dn_ok;
        mwi_next = acc_next && dn_is_mem && dn_is_write
            && ctl.write_invalidate_promotion_enable;
        // Poison travels on regardless of parity response enable
        bp_next = acc_next && dn_poisoned;
        claim_next = up_valid && (up_is_mem || up_is_io)
            && ctl.upstream_initiator_enable;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            acc_reg <= 1'b0;
            ur_reg <= 1'b0;
            mwi_reg <= 1'b0;
            bp_reg <= 1'b0;
            claim_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            ur_reg <= ur_next;
            mwi_reg <= mwi_next;
            bp_reg <= bp_next;
            claim_reg <= claim_next;
        end
    end

    assign ctl.poison_seen = dn_valid && dn_poisoned;
    assign ctl.poison_parity_event = dn_valid && dn_poisoned && dn_is_write
        && ctl.parity_response_enable;
    assign dn_accept = acc_reg;
    assign dn_unsupported = ur_reg;
    assign dn_write_invalidate = mwi_reg;
    assign dn_bad_parity = bp_reg;
    assign up_claim = claim_reg;
endmodule
`default_nettype wire

// ### test/pcb_cfg_header_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_cfg_header_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration port
    input wire logic cfg_done,
    input wire logic [31:0] cfg_rdata,
    // Downstream gate
    input wire logic dn_valid,
    input wire logic dn_is_mem,
    input wire logic dn_is_io,
    input wire logic dn_poisoned,
    input wire logic dn_accept,
    input wire logic dn_unsupported,
    input wire logic dn_write_invalidate,
    input wire logic dn_bad_parity,
    // PCI side
    input wire logic up_valid,
    input wire logic up_is_mem,
    input wire logic up_is_io,
    input wire logic up_claim,
    input wire logic link_initiate_allowed
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_dn_none;
        dn_valid && !dn_is_mem && !dn_is_io;
    endsequence
    sequence s_up_off;
        up_valid && !link_initiate_allowed;
    endsequence
    a_none_refused: assert property (s_dn_none |=> dn_unsupported)
        else $error("untyped request not refused");
    a_up_blocked: assert property (s_up_off |=> !up_claim)
        else $error("claim while initiator disabled");
    a_claim_cause: assert property (up_claim |-> $past(up_valid && (up_is_mem || up_is_io) && link_initiate_allowed))
        else $error("claim without cycle");
    a_promote_accept: assert property (dn_write_invalidate |-> dn_accept)
        else $error("promotion without accept");
    a_poison_parity: assert property (dn_valid && dn_poisoned |=> dn_bad_parity == dn_accept)
        else $error("poisoned request parity wrong");
    a_one_answer: assert property (dn_valid |=> dn_accept != dn_unsupported)
        else $error("request answer count wrong");
    a_accept_cause: assert property (dn_accept |-> $past(dn_valid))
        else $error("accept without request");
    a_reset_quiet: assert property ($fell(rst) |-> cfg_rdata == 32'h0 && !cfg_done)
        else $error("outputs not quiet after reset");
endmodule
bind pcb_cfg_header pcb_cfg_header_sva chk (.*);
`default_nettype wire

// ### test/pcb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_host_model (
    // Clock and answer
    input wire logic clock,
    input wire logic cfg_done,
    input wire logic [31:0] cfg_rdata,
    // Request
    output logic cfg_valid,
    output logic cfg_write,
    output logic [7:0] cfg_offset,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata
);
    initial begin
        {cfg_valid, cfg_write, cfg_offset, cfg_byte_en, cfg_wdata} = '0;
    end
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clock);
        {cfg_valid, cfg_write, cfg_offset, cfg_byte_en, cfg_wdata} <= {1'b1, wr, ofs, be, wd};
        @(posedge clock);
        cfg_valid <= 1'b0;
        // Stale data would hide a lane mix-up
        cfg_wdata <= ~wd;
        n = 0;
        #1;
        while (cfg_done !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        rd = cfg_rdata;
    endtask
endmodule
`default_nettype wire

// ### test/tb_bridge_config_header_cmd_status.sv
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_config_header_cmd_status;
    import pcb_pkg::*;
    logic clock, rst, cfg_valid, cfg_write, cfg_done, link_initiate_allowed, err_msg_send;
    logic [7:0] cfg_offset;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic dn_valid, dn_is_mem, dn_is_io, dn_is_write, dn_poisoned;
    logic dn_accept, dn_unsupported, dn_write_invalidate, dn_bad_parity;
    logic cpl_poisoned_data, cpl_ur_received, cpl_ca_received, cpl_ca_sent;
    logic up_valid, up_is_mem, up_is_io, up_claim, pci_serr_n;
    int bad_count, checked, hits;
    pcb_cfg_header uut (.*);
    pcb_host_model host (.*);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (2000) @(posedge clock);
        bad_count++;
        close_out();
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
        host.xfer(1'b0, ofs, 4'h0, 32'h0, rd);
        // A missing strobe also catches a host model that gave up waiting
        chk("cfg_done", 32'h1, {31'h0, cfg_done});
        chk("cfg_rdata", exp, rd);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] wd);
        host.xfer(1'b1, ofs, be, wd, rd);
        chk("cfg_done", 32'h1, {31'h0, cfg_done});
        chk("cfg_rdata", 32'h0, rd);
    endtask
    // Completion events: poisoned data, unsupported, abort received, abort sent
    task automatic cpl(input logic [3:0] ev);
        @(posedge clock);
        {cpl_poisoned_data, cpl_ur_received, cpl_ca_received, cpl_ca_sent} <= ev;
        @(posedge clock);
        {cpl_poisoned_data, cpl_ur_received, cpl_ca_received, cpl_ca_sent} <= 4'h0;
    endtask
    // Request bits: valid, mem, io, write, poisoned; answer: accept, ur, promote, parity
    task automatic dn(input logic [4:0] req, input logic [3:0] exp);
        @(posedge clock);
        {dn_valid, dn_is_mem, dn_is_io, dn_is_write, dn_poisoned} <= req;
        @(posedge clock);
        dn_valid <= 1'b0;
        #1;
        chk("dn_answer", {28'h0, exp},
            {28'h0, dn_accept, dn_unsupported, dn_write_invalidate, dn_bad_parity});
    endtask
    task automatic up(input logic [1:0] req, input logic exp);
        @(posedge clock);
        {up_valid, up_is_mem, up_is_io} <= {1'b1, req};
        @(posedge clock);
        up_valid <= 1'b0;
        #1;
        chk("up_claim", {31'h0, exp}, {31'h0, up_claim});
    endtask
    task automatic serr(input logic [31:0] exp);
        hits = 0;
        @(posedge clock);
        pci_serr_n <= 1'b0;
        repeat (8) begin
            @(posedge clock);
            #1;
            hits += int'(err_msg_send === 1'b1);
        end
        @(posedge clock);
        pci_serr_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk("err_msg_send", exp, hits);
    endtask
    initial begin
        {rst, dn_valid, dn_is_mem, dn_is_io, dn_is_write, dn_poisoned} = 6'h20;
        {cpl_poisoned_data, cpl_ur_received, cpl_ca_received, cpl_ca_sent} = 4'h0;
        {up_valid, up_is_mem, up_is_io, pci_serr_n} = 4'h1;
        bad_count = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rdc(OFS_MAKER, {PART_CODE, MAKER_CODE});
        rdc(OFS_CTRL, {STAT_RESET, CTRL_RESET});
        wr(OFS_MAKER, 4'hF, 32'hFFFF_FFFF);
        rdc(OFS_MAKER, {PART_CODE, MAKER_CODE});
        wr(OFS_CTRL, 4'h3, 32'h0000_FFFF);
        rdc(OFS_CTRL, 32'h0010_0157);
        chk("link_init", 32'h1, {31'h0, link_initiate_allowed});
        wr(OFS_CTRL, 4'h3, 32'h0000_0000);
        chk("link_init", 32'h0, {31'h0, link_initiate_allowed});
        dn(5'b11000, 4'h4);
        dn(5'b10100, 4'h4);
        up(2'b10, 1'b0);
        up(2'b01, 1'b0);
        wr(OFS_CTRL, 4'h3, 32'h0000_0007);
        dn(5'b11000, 4'h8);
        dn(5'b10100, 4'h8);
        dn(5'b10000, 4'h4);
        dn(5'b11010, 4'h8);
        up(2'b10, 1'b1);
        up(2'b01, 1'b1);
        wr(OFS_CTRL, 4'h3, 32'h0000_0052);
        dn(5'b11011, 4'hB);
        rdc(OFS_CTRL, 32'h8110_0052);
        // Clear every status flag while turning parity response off
        wr(OFS_CTRL, 4'hF, 32'hFFFF_0012);
        dn(5'b11011, 4'hB);
        rdc(OFS_CTRL, 32'h8010_0012);
        wr(OFS_CTRL, 4'hF, 32'hFFFF_0100);
        serr(32'h1);
        rdc(OFS_CTRL, 32'h4010_0100);
        wr(OFS_CTRL, 4'hF, 32'hFFFF_0000);
        serr(32'h0);
        rdc(OFS_CTRL, 32'h0010_0000);
        rdc(8'h10, 32'h0);
        wr(OFS_CTRL, 4'h3, 32'h0000_0040);
        cpl(4'hF);
        rdc(OFS_CTRL, 32'h3910_0040);
        // Clear lands on the same edge as a new event; the event must survive
        fork
            wr(OFS_CTRL, 4'hC, 32'hFFFF_0000);
            cpl(4'h4);
        join
        rdc(OFS_CTRL, 32'h2010_0040);
        wr(OFS_CTRL, 4'hF, 32'hFFFF_0000);
        cpl(4'h8);
        rdc(OFS_CTRL, 32'h0010_0000);
        close_out();
    end
endmodule
`default_nettype wire
